// File: rtl/pmsf_pkg.sv
// Package: register map, field layout and constants of the status block
package pmsf_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_CHG_LDO = 8'h03;
    localparam logic [7:0] OFS_BUCK_LOOP = 8'h04;
    localparam logic [7:0] OFS_BAT_BOOST = 8'h05;
    localparam logic [7:0] OFS_FLAGS = 8'h06;
    localparam logic [7:0] OFS_FLAG_MASK = 8'h0A;

    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // ************************************************************
    // Bit positions
    // ************************************************************
    localparam int B03_CHG_THERMAL = 7;
    localparam int B03_LIN_THERMAL = 5;
    localparam int B03_LIN2_UVLO = 4;
    localparam int B03_LIN1_UVLO = 3;

    localparam int B04_BB_FAULT = 7;
    localparam int B04_HARV_CMP = 6;
    localparam int B04_SYS_LIM = 5;
    localparam int B04_IN_VLIM = 4;
    localparam int B04_STEP = 3;
    localparam int B04_BUCK1 = 2;
    localparam int B04_BUCK2 = 1;
    localparam int B04_BUCK3 = 0;

    localparam int B05_BAT_GOOD = 7;
    localparam int B05_BAT_REG = 6;
    localparam int B05_BB_MIRROR = 5;

    localparam int B06_THM_ZONE = 7;
    localparam int B06_CHG_STATE = 6;
    localparam int B06_SINGLES_W = 6;

    // Overvoltage/valid pair that marks a good input
    localparam logic [1:0] GOOD_INPUT_PAIR = 2'h1;

    // ************************************************************
    // Watched vector: {zone[2:0], state[2:0], six single flags}
    // ************************************************************
    localparam int FIELD_W = 3;
    localparam int WATCH_W = 12;
    localparam int WATCH_ZONE_LSB = 9;
    localparam int WATCH_STATE_LSB = 6;
    localparam int WATCH_OVP = 4;
    localparam int WATCH_OK = 3;
    localparam int LIN_SW_W = 4;
    localparam int STAT_W = 18;

    // Synchroniser warm-up: stages plus history before changes count
    localparam int WARM_W = 3;

endpackage : pmsf_pkg

// File: rtl/pmsf_sync_change.sv
// Module: two-flop synchroniser with change detection per bit
`timescale 1ns/1ns
module pmsf_sync_change #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] rawIn,
    output logic [W-1:0] syncOut,
    output logic [W-1:0] changed
);

    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;
    logic [W-1:0] hist_r;
    logic [pmsf_pkg::WARM_W-1:0] warm_r;

    // ************************************************************
    // Synchroniser; stage1 feeds only stage2
    // ************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage1_r <= '0;
            stage2_r <= '0;
            hist_r <= '0;
        end else begin
            stage1_r <= rawIn;
            stage2_r <= stage1_r;
            hist_r <= stage2_r;
        end
    end

    // No change counts until history holds real data, else every
    // input high at reset release would raise a false flag
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            warm_r <= '0;
        end else begin
            warm_r <= {warm_r[pmsf_pkg::WARM_W-2:0], 1'h1};
        end
    end

    assign syncOut = stage2_r;

    // ************************************************************
    // One pulse per settled transition
    // ************************************************************
    for (genvar i = 0; i < W; i++) begin : g_change
        assign changed[i] = warm_r[pmsf_pkg::WARM_W-1]
                            & (stage2_r[i] ^ hist_r[i]);
    end

endmodule : pmsf_sync_change

// File: rtl/pmsf_status_flags.sv
// Module: status registers, change flags, flag mask and interrupt
`timescale 1ns/1ns
// Notes on behaviour
// - 0x03 bit7 charger thermal shutdown, input present
// - 0x03 bit5 any linear/switch thermal shutdown
// - 0x03 bits4,3 second/first linear undervoltage
// - Buck-boost fault at 0x04 bit7, 0x05 bit5
// - 0x04 bit6 harvester compare, harvester enabled
// - 0x04 bit5 system rail limit, good charging
// - 0x04 bit4 input voltage limit, good input
// - 0x04 bit3 step charge, good charging
// - 0x04 bits2..0 buck one..three thermal
// - 0x05 bit7 battery good, one without input
// - 0x05 bit6 regulation reached, good charging, no rail limit
// - 0x06 bits7,6 zone and state changed
// - 0x06 bits5..0 single status changes
// - Overvoltage/valid pair 01 means good input
// - Interrupt only for flags with mask one
module pmsf_status_flags (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic interrupt,
    input wire logic chargerEnable,
    input wire logic harvesterEnable,
    input wire logic chargerInput,
    input wire logic chargerThermalShutdown,
    input wire logic [3:0] linearSwitchThermalShutdown,
    input wire logic secondLinearUndervoltage,
    input wire logic firstLinearUndervoltage,
    input wire logic buckboostFault,
    input wire logic harvesterBatteryCompare,
    input wire logic systemRailChargeLimit,
    input wire logic inputVoltageLimitActive,
    input wire logic stepChargeActive,
    input wire logic buckOneThermalShutdown,
    input wire logic buckTwoThermalShutdown,
    input wire logic buckThreeThermalShutdown,
    input wire logic batteryAboveUndervoltage,
    input wire logic batteryRegulationReached,
    input wire logic [2:0] thermistorZone,
    input wire logic [2:0] chargerState,
    input wire logic inputCurrentLimited,
    input wire logic inputOvervoltage,
    input wire logic inputValid,
    input wire logic tempProfileShutdown,
    input wire logic tempProfileReduction,
    input wire logic chargeTimeout
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************
    function automatic logic inputGood(input logic present,
                                       input logic ovp,
                                       input logic ok);
        inputGood = present && ({ovp, ok} == pmsf_pkg::GOOD_INPUT_PAIR);
    endfunction : inputGood

    function automatic logic hitAddr(input logic [7:0] addr,
                                     input logic [7:0] ofs);
        hitAddr = (addr == ofs);
    endfunction : hitAddr

    // ************************************************************
    // Synchronised inputs
    // ************************************************************
    logic [pmsf_pkg::STAT_W-1:0] statSync;
    logic [pmsf_pkg::WATCH_W-1:0] watchSync;
    logic [pmsf_pkg::WATCH_W-1:0] watchChanged;
    logic inS;
    logic chgThmS;
    logic [pmsf_pkg::LIN_SW_W-1:0] linThmS;
    logic lin2UvS;
    logic lin1UvS;
    logic bbFaultS;
    logic harvCmpS;
    logic sysLimS;
    logic inVLimS;
    logic stepS;
    logic buck1S;
    logic buck2S;
    logic buck3S;
    logic batUvS;
    logic batRegS;
    logic ovpS;
    logic okS;

    pmsf_sync_change #(.W(pmsf_pkg::STAT_W)) u_stat_sync (
        .mclk(mclk),
        .nrst(nrst),
        .rawIn({chargerInput, chargerThermalShutdown,
                linearSwitchThermalShutdown, secondLinearUndervoltage,
                firstLinearUndervoltage, buckboostFault,
                harvesterBatteryCompare, systemRailChargeLimit,
                inputVoltageLimitActive, stepChargeActive,
                buckOneThermalShutdown, buckTwoThermalShutdown,
                buckThreeThermalShutdown, batteryAboveUndervoltage,
                batteryRegulationReached}),
        .syncOut(statSync),
        .changed()
    );

    assign {inS, chgThmS, linThmS, lin2UvS, lin1UvS, bbFaultS, harvCmpS,
            sysLimS, inVLimS, stepS, buck1S, buck2S, buck3S, batUvS,
            batRegS} = statSync;

    pmsf_sync_change #(.W(pmsf_pkg::WATCH_W)) u_watch_sync (
        .mclk(mclk),
        .nrst(nrst),
        .rawIn({thermistorZone, chargerState, inputCurrentLimited,
                inputOvervoltage, inputValid, tempProfileShutdown,
                tempProfileReduction, chargeTimeout}),
        .syncOut(watchSync),
        .changed(watchChanged)
    );

    // Pair taken from the watched copy so flags and status agree
    assign ovpS = watchSync[pmsf_pkg::WATCH_OVP];
    assign okS = watchSync[pmsf_pkg::WATCH_OK];

    // ************************************************************
    // Status register contents
    // ************************************************************
    logic goodIn;
    logic chgOn;
    logic sysLimQ;
    logic [7:0] st03;
    logic [7:0] st04;
    logic [7:0] st05;

    assign goodIn = inputGood(inS, ovpS, okS);
    assign chgOn = goodIn && chargerEnable;
    assign sysLimQ = sysLimS && chgOn;

    // Bits outside their validity window read zero rather than noise
    always_comb begin
        st03 = pmsf_pkg::ZERO_BYTE;
        st03[pmsf_pkg::B03_CHG_THERMAL] = chgThmS && inS;
        st03[pmsf_pkg::B03_LIN_THERMAL] = |linThmS;
        st03[pmsf_pkg::B03_LIN2_UVLO] = lin2UvS;
        st03[pmsf_pkg::B03_LIN1_UVLO] = lin1UvS;
    end

    always_comb begin
        st04 = pmsf_pkg::ZERO_BYTE;
        st04[pmsf_pkg::B04_BB_FAULT] = bbFaultS;
        st04[pmsf_pkg::B04_HARV_CMP] = harvCmpS && harvesterEnable;
        st04[pmsf_pkg::B04_SYS_LIM] = sysLimQ;
        st04[pmsf_pkg::B04_IN_VLIM] = inVLimS && goodIn;
        st04[pmsf_pkg::B04_STEP] = stepS && chgOn;
        st04[pmsf_pkg::B04_BUCK1] = buck1S;
        st04[pmsf_pkg::B04_BUCK2] = buck2S;
        st04[pmsf_pkg::B04_BUCK3] = buck3S;
    end

    always_comb begin
        st05 = pmsf_pkg::ZERO_BYTE;
        st05[pmsf_pkg::B05_BAT_GOOD] = !inS || batUvS;
        st05[pmsf_pkg::B05_BAT_REG] = batRegS && chgOn && !sysLimQ;
        st05[pmsf_pkg::B05_BB_MIRROR] = bbFaultS;
    end

    // ************************************************************
    // Change flags, mask and interrupt
    // ************************************************************
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic [7:0] flagSet;
    logic [7:0] flagClr;
    logic [7:0] mask_r;
    logic irq_r;

    logic zoneChg;
    logic stateChg;

    // Any bit of a three-bit field moving raises that field's one flag
    assign zoneChg = |watchChanged[pmsf_pkg::WATCH_ZONE_LSB +:
                                   pmsf_pkg::FIELD_W];
    assign stateChg = |watchChanged[pmsf_pkg::WATCH_STATE_LSB +:
                                    pmsf_pkg::FIELD_W];

    always_comb begin
        flagSet = pmsf_pkg::ZERO_BYTE;
        flagSet[pmsf_pkg::B06_THM_ZONE] = zoneChg;
        flagSet[pmsf_pkg::B06_CHG_STATE] = stateChg;
        flagSet[pmsf_pkg::B06_SINGLES_W-1:0] =
            watchChanged[pmsf_pkg::B06_SINGLES_W-1:0];
    end

    // Write one to clear; a change in the same cycle keeps the flag
    assign flagClr = (regWrite && hitAddr(regAddr, pmsf_pkg::OFS_FLAGS))
                     ? regWdata : pmsf_pkg::ZERO_BYTE;
    assign flags_nxt = (flags_r & ~flagClr) | flagSet;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flags_r <= pmsf_pkg::FLAG_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mask_r <= pmsf_pkg::MASK_RESET;
        end else if (regWrite
                     && hitAddr(regAddr, pmsf_pkg::OFS_FLAG_MASK)) begin
            mask_r <= regWdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'h0;
        end else begin
            irq_r <= |(flags_r & mask_r);
        end
    end

    // ************************************************************
    // Read port: data appears one edge after the read strobe
    // ************************************************************
    logic [7:0] regRdata_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            regRdata_r <= pmsf_pkg::ZERO_BYTE;
        end else if (regRead) begin
            case (regAddr)
                pmsf_pkg::OFS_CHG_LDO: begin
                    regRdata_r <= st03;
                end
                pmsf_pkg::OFS_BUCK_LOOP: begin
                    regRdata_r <= st04;
                end
                pmsf_pkg::OFS_BAT_BOOST: begin
                    regRdata_r <= st05;
                end
                pmsf_pkg::OFS_FLAGS: begin
                    regRdata_r <= flags_r;
                end
                pmsf_pkg::OFS_FLAG_MASK: begin
                    regRdata_r <= mask_r;
                end
                default: begin
                    regRdata_r <= pmsf_pkg::ZERO_BYTE;
                end
            endcase
        end
    end

    assign regRdata = regRdata_r;
    assign interrupt = irq_r;

endmodule : pmsf_status_flags

// File: bench/pmsf_status_checker.sv
// Checker: port-level properties of the status and flag block
`timescale 1ns/1ns
module pmsf_status_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic interrupt,
    input wire logic chargerInput,
    input wire logic secondLinearUndervoltage,
    input wire logic buckboostFault,
    input wire logic inputOvervoltage
);
    // Four steady samples cover the synchroniser plus the status stage
    logic rd03;
    logic rd04;
    logic rd05;
    logic wrMask;
    assign rd03 = regRead && regAddr == pmsf_pkg::OFS_CHG_LDO;
    assign rd04 = regRead && regAddr == pmsf_pkg::OFS_BUCK_LOOP;
    assign rd05 = regRead && regAddr == pmsf_pkg::OFS_BAT_BOOST;
    assign wrMask = regWrite && regAddr == pmsf_pkg::OFS_FLAG_MASK;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    thermal_idle_a: assert property (
        (!chargerInput) [*4] ##0 rd03 |=> !regRdata[7])
        else $error("thermal bit set without input");
    undervolt_two_a: assert property (
        secondLinearUndervoltage [*4] ##0 rd03 |=> regRdata[4])
        else $error("second undervoltage bit missing");
    unused_low_a: assert property (
        rd03 |=> regRdata[6] == 1'h0 && regRdata[2:0] == 3'h0)
        else $error("unused bits of 0x03 not zero");
    fault_high_a: assert property (
        buckboostFault [*4] ##0 rd04 |=> regRdata[7])
        else $error("fault bit of 0x04 missing");
    fault_mirror_a: assert property (
        buckboostFault [*4] ##0 rd05 |=> regRdata[5])
        else $error("fault bit of 0x05 missing");
    bad_input_a: assert property (
        inputOvervoltage [*4] ##0 rd04 |=> regRdata[5:3] == 3'h0)
        else $error("loop bits set with overvoltage");
    battery_default_a: assert property (
        (!chargerInput) [*4] ##0 rd05 |=> regRdata[7])
        else $error("battery bit low without input");
    mask_off_a: assert property (
        wrMask && regWdata == 8'h00 |=> ##1 !interrupt)
        else $error("interrupt with all flags masked");
endmodule : pmsf_status_checker

bind pmsf_status_flags pmsf_status_checker chk (.mclk(mclk), .nrst(nrst),
    .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .interrupt(interrupt),
    .chargerInput(chargerInput), .inputOvervoltage(inputOvervoltage),
    .secondLinearUndervoltage(secondLinearUndervoltage),
    .buckboostFault(buckboostFault));

// File: bench/pmsf_host_model.sv
// Host model: register reads and writes over the access port
`timescale 1ns/1ns
module pmsf_host_model (
    input wire logic mclk,
    input wire logic [7:0] regRdata,
    output logic [7:0] regAddr,
    output logic regRead,
    output logic regWrite,
    output logic [7:0] regWdata
);
    initial begin
        regAddr = 8'h00;
        regRead = 1'h0;
        regWrite = 1'h0;
        regWdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge mclk);
        regWrite <= 1'h0;
        // Released lines must not keep a value the block could reuse
        regWdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge mclk);
        regRead <= 1'h0;
        regAddr <= ~a;
        #1;
        d = regRdata;
    endtask : rd
endmodule : pmsf_host_model

// File: bench/tb_top.sv
// Testbench: status registers, change flags and interrupt mask
`timescale 1ns/1ns
module tb_top;
    logic mclk;
    logic nrst;
    logic [31:0] st;
    logic [7:0] regAddr;
    logic regRead;
    logic regWrite;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic interrupt;
    logic [7:0] got;
    logic [7:0] fexp;
    logic [31:0] pats [6] = '{32'hFFFF_FFFF, 32'hFFFF_DFEF, 32'hFFF7_FFEF,
        32'h3FF7_EFEF, 32'h2200_0000, 32'hDF6B_5AE8};
    int numErrors;
    int checksDone;
    pmsf_host_model host (.mclk(mclk), .regRdata(regRdata), .regAddr(regAddr),
        .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata));
    pmsf_status_flags dut (.mclk(mclk), .nrst(nrst), .regAddr(regAddr),
        .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
        .regRdata(regRdata), .interrupt(interrupt),
        .chargerEnable(st[31]), .harvesterEnable(st[30]),
        .chargerInput(st[29]), .chargerThermalShutdown(st[28]),
        .linearSwitchThermalShutdown(st[27:24]),
        .secondLinearUndervoltage(st[23]), .firstLinearUndervoltage(st[22]),
        .buckboostFault(st[21]), .harvesterBatteryCompare(st[20]),
        .systemRailChargeLimit(st[19]), .inputVoltageLimitActive(st[18]),
        .stepChargeActive(st[17]), .buckOneThermalShutdown(st[16]),
        .buckTwoThermalShutdown(st[15]), .buckThreeThermalShutdown(st[14]),
        .batteryAboveUndervoltage(st[13]), .batteryRegulationReached(st[12]),
        .thermistorZone(st[11:9]), .chargerState(st[8:6]),
        .inputCurrentLimited(st[5]), .inputOvervoltage(st[4]),
        .inputValid(st[3]), .tempProfileShutdown(st[2]),
        .tempProfileReduction(st[1]), .chargeTimeout(st[0]));
    function automatic logic [7:0] expStat(input logic [7:0] a,
        input logic [31:0] s);
        logic good;
        logic lim;
        good = s[29] & ~s[4] & s[3];
        lim = s[19] & good & s[31];
        case (a)
            8'h03: expStat = {s[28] & s[29], 1'h0, |s[27:24], s[23:22], 3'h0};
            8'h04: expStat = {s[21], s[20] & s[30], lim, s[18] & good,
                s[17] & good & s[31], s[16:14]};
            8'h05: expStat = {~s[29] | s[13], s[12] & good & s[31] & ~lim,
                s[21], 5'h00};
            default: expStat = 8'h00;
        endcase
    endfunction : expStat
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Inputs change one edge after the call, then settle through the sync
    task automatic apply(input logic [31:0] v);
        @(posedge mclk);
        st <= v;
        repeat (4) @(posedge mclk);
    endtask : apply
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrapUp
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        numErrors++;
        wrapUp();
    end
    initial begin
        nrst = 1'h0;
        st = 32'h0000_0000;
        numErrors = 0;
        checksDone = 0;
        repeat (6) @(posedge mclk);
        nrst <= 1'h1;
        for (logic [7:0] a = 8'h03; a < 8'h0C; a++) begin
            host.rd(a, got);
            check("reset map", got, expStat(a, st));
        end
        $display("test reset done");
        foreach (pats[p]) begin
            apply(pats[p]);
            for (logic [7:0] a = 8'h03; a < 8'h06; a++) begin
                host.wr(a, 8'hA5);
                host.rd(a, got);
                check("status", got, expStat(a, st));
            end
        end
        $display("test status done");
        host.wr(pmsf_pkg::OFS_FLAG_MASK, 8'hFF);
        for (int i = 0; i < 12; i++) begin
            host.wr(pmsf_pkg::OFS_FLAGS, 8'hFF);
            apply(st ^ (32'h0000_0001 << i));
            fexp = (i > 8) ? 8'h80 : (i > 5) ? 8'h40 : 8'h01 << i;
            host.rd(pmsf_pkg::OFS_FLAGS, got);
            check("flag", got, fexp);
            check("irq on", {7'h00, interrupt}, 8'h01);
            apply(st ^ (32'h0000_0001 << i));
            host.rd(pmsf_pkg::OFS_FLAGS, got);
            check("sticky", got, fexp);
            host.wr(pmsf_pkg::OFS_FLAGS, fexp);
            host.rd(pmsf_pkg::OFS_FLAGS, got);
            check("cleared", got, 8'h00);
            check("irq off", {7'h00, interrupt}, 8'h00);
        end
        $display("test flags done");
        host.wr(pmsf_pkg::OFS_FLAG_MASK, 8'hF7);
        apply(st ^ 32'h0000_0008);
        host.rd(pmsf_pkg::OFS_FLAGS, got);
        check("masked flag", got, 8'h08);
        check("masked irq", {7'h00, interrupt}, 8'h00);
        host.wr(pmsf_pkg::OFS_FLAG_MASK, 8'h00);
        host.rd(pmsf_pkg::OFS_FLAG_MASK, got);
        check("mask rw", got, 8'h00);
        host.wr(pmsf_pkg::OFS_FLAG_MASK, 8'hFF);
        host.rd(pmsf_pkg::OFS_FLAG_MASK, got);
        check("mask rw", got, 8'hFF);
        check("unmasked irq", {7'h00, interrupt}, 8'h01);
        $display("test mask done");
        // Mid-run reset: state returns to zero, static inputs raise no flag
        @(posedge mclk);
        nrst <= 1'h0;
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        check("reset irq", {7'h00, interrupt}, 8'h00);
        host.rd(pmsf_pkg::OFS_FLAG_MASK, got);
        check("reset mask", got, 8'h00);
        host.rd(pmsf_pkg::OFS_FLAGS, got);
        check("reset flags", got, 8'h00);
        $display("test reset again done");
        wrapUp();
    end
endmodule : tb_top
